// file: verilog/rxwb_engine.sv
/*
  Receive descriptor engine: walks a ring of descriptors in system memory,
  hands host-owned-to-controller buffers to the receive datapath and writes
  status back, returning ownership. Registers over APB.
  Assumes a 16-bit memory port that holds memAck high for one cycle per
  access, and a datapath that fills at most one granted buffer at a time.

  // How it works
  // - Bit 15 of the second descriptor word gives ownership, one meaning controller, and only the owner works on it.
  // - The controller clears ownership after filling a buffer; the host sets it again after emptying it.
  // - Once an entry is handed over, its former owner leaves every field of it alone.
  // - The error summary bit is the OR of framing, overrun, checksum and chain buffer faults.
  // - The framing fault needs both a non-octet length and a checksum error.
  // - The framing fault is given only on a last buffer without overrun and never in loopback.
  // - The overrun flag marks lost frame data and stands only where the last buffer flag is clear.
  // - A FIFO overrun beside a chain buffer fault is reported only if both arise together.
  // - The first buffer flag is written by the controller, or left to the host in split receive mode.
  // - The last buffer flag marks the final buffer; with the first flag it means a single buffer frame.
  // - The low byte holds the upper address bits, written by the host and kept intact here.
  // - The 24-bit buffer address is the upper byte joined to the sixteen lower bits.
  // - The checksum flag reports a bad frame check sequence, valid on a last buffer without overrun.
  // - A chain buffer fault is set when the next buffer is host owned or the FIFO overran before the poll.
*/
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module rxwb_engine
    import rxwb_pkg::*;
#(
    parameter int RING_IDX_W = 8
)
(
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Descriptor memory master
    output logic memReq,
    output logic memWe,
    output logic [23:0] memAddr,
    output logic [15:0] memWdata,
    input wire logic memAck,
    input wire logic [15:0] memRdata,
    // Receive datapath
    output logic bufGrant,
    output logic [23:0] bufAddr,
    input wire logic fillDone,
    input wire logic fillLast,
    input wire logic fillFcsError,
    input wire logic fillNonOctet,
    input wire logic fifoOverrun,
    output logic chainAbort
);

    rxwb_state_t state_reg;
    rxwb_after_t after_reg;
    logic [31:0] ctrl_reg;
    logic [23:0] ringBase_reg;
    logic [RING_IDX_W-1:0] ringLen_reg;
    logic [RING_IDX_W-1:0] curIdx_reg;
    logic [RING_IDX_W-1:0] wbIdx_reg;
    logic [15:0] lowWord_reg;
    logic [15:0] hiWord_reg;
    logic [15:0] lastStatus_reg;
    logic [31:0] frameCount_reg;
    logic [15:0] pollCount_reg;
    logic pending_reg;
    logic overrunSeen_reg;
    logic firstNext_reg;
    logic chainAbort_reg;
    // Flags of the buffer being written back
    logic [15:0] flgWord_reg;
    logic flgFirst_reg;
    logic flgLast_reg;
    logic flgFcs_reg;
    logic flgNonOctet_reg;
    logic flgOverrun_reg;
    logic flgChain_reg;
    logic flgSimult_reg;

    logic apbWrite;
    logic enable;
    logic loopback;
    logic splitRxIrqMode;
    logic ownedByController;
    logic [RING_IDX_W-1:0] nextIdx;
    logic [15:0] statusWord;
    logic overrunNow;

    assign apbWrite = psel & penable & pwrite;
    assign enable = ctrl_reg[CTRL_ENABLE_BIT];
    assign loopback = ctrl_reg[CTRL_LOOPBACK_BIT];
    assign splitRxIrqMode = ctrl_reg[CTRL_SPLIT_BIT];
    assign ownedByController = hiWord_reg[DESC_OWN_BIT];
    // An overrun in the deciding cycle itself still counts as before the poll
    assign overrunNow = overrunSeen_reg | (pending_reg & fifoOverrun);
    assign nextIdx = (curIdx_reg + 1'b1 >= ringLen_reg) ? '0 : curIdx_reg + 1'b1;

    // Slave answers in the access phase with no wait states
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(paddr == REG_CTRL || paddr == REG_RING_BASE ||
        paddr == REG_RING_LEN || paddr == REG_STATUS || paddr == REG_FRAME_COUNT);

    // Register writes; ring geometry is used as soon as written, also while enabled
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= CTRL_RESET;
            ringBase_reg <= RING_BASE_RESET;
            ringLen_reg <= RING_LEN_RESET[RING_IDX_W-1:0];
        end
        else if (apbWrite)
        begin
            case (paddr)
                REG_CTRL: ctrl_reg <= pwdata & 32'h0000_0023;
                REG_RING_BASE: ringBase_reg <= pwdata[23:0];
                REG_RING_LEN: ringLen_reg <= (pwdata[RING_IDX_W-1:0] == '0) ? RING_LEN_RESET[RING_IDX_W-1:0]
                    : pwdata[RING_IDX_W-1:0];
                default: ;
            endcase
        end
    end

    // Read mux
    always_comb
    begin
        prdata = 32'h0000_0000;
        case (paddr)
            REG_CTRL: prdata = ctrl_reg;
            REG_RING_BASE: prdata = {8'h00, ringBase_reg};
            REG_RING_LEN: prdata[RING_IDX_W-1:0] = ringLen_reg;
            REG_STATUS: prdata = {5'h00, state_reg, pending_reg, curIdx_reg[6:0], lastStatus_reg};
            REG_FRAME_COUNT: prdata = frameCount_reg;
            default: prdata = 32'h0000_0000;
        endcase
    end

    // Main sequencer
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            after_reg <= AFTER_ADVANCE;
            curIdx_reg <= '0;
            wbIdx_reg <= '0;
            lowWord_reg <= 16'h0000;
            hiWord_reg <= 16'h0000;
            memAddr <= 24'h00_0000;
            pollCount_reg <= 16'h0000;
            pending_reg <= 1'b0;
            firstNext_reg <= 1'b1;
            chainAbort_reg <= 1'b0;
        end
        else
        begin
            chainAbort_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (enable)
                    begin
                        memAddr <= ringBase_reg + DESC_STRIDE * 24'(curIdx_reg);
                        state_reg <= ST_RD_LO;
                    end
                end
                ST_RD_LO:
                begin
                    if (memAck)
                    begin
                        lowWord_reg <= memRdata;
                        memAddr <= memAddr + WORD1_OFFSET;
                        state_reg <= ST_RD_HI;
                    end
                end
                ST_RD_HI:
                begin
                    if (memAck)
                    begin
                        hiWord_reg <= memRdata;
                        state_reg <= ST_DECIDE;
                    end
                end
                ST_DECIDE:
                begin
                    if (pending_reg)
                    begin
                        // Previous buffer of the frame still waits for its status
                        pending_reg <= 1'b0;
                        memAddr <= ringBase_reg + DESC_STRIDE * 24'(wbIdx_reg) + WORD1_OFFSET;
                        state_reg <= ST_WRITE;
                        if (ownedByController && !overrunNow)
                            after_reg <= AFTER_GRANT;
                        else
                        begin
                            after_reg <= AFTER_POLL;
                            chainAbort_reg <= 1'b1;
                            firstNext_reg <= 1'b1;
                        end
                    end
                    else if (ownedByController)
                        state_reg <= ST_GRANT;
                    else
                    begin
                        pollCount_reg <= 16'(POLL_CYCLES);
                        state_reg <= ST_POLL;
                    end
                end
                ST_GRANT:
                begin
                    if (fillDone || fifoOverrun)
                    begin
                        wbIdx_reg <= curIdx_reg;
                        if (fillLast || fifoOverrun)
                        begin
                            memAddr <= ringBase_reg + DESC_STRIDE * 24'(curIdx_reg) + WORD1_OFFSET;
                            after_reg <= AFTER_ADVANCE;
                            firstNext_reg <= 1'b1;
                            state_reg <= ST_WRITE;
                        end
                        else
                        begin
                            // Hold this status until the next entry is known
                            pending_reg <= 1'b1;
                            firstNext_reg <= 1'b0;
                            curIdx_reg <= nextIdx;
                            memAddr <= ringBase_reg + DESC_STRIDE * 24'(nextIdx);
                            state_reg <= ST_RD_LO;
                        end
                    end
                end
                ST_WRITE:
                begin
                    if (memAck)
                    begin
                        case (after_reg)
                            AFTER_GRANT: state_reg <= ST_GRANT;
                            AFTER_POLL:
                            begin
                                pollCount_reg <= 16'(POLL_CYCLES);
                                state_reg <= ST_POLL;
                            end
                            default:
                            begin
                                curIdx_reg <= nextIdx;
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_POLL:
                begin
                    if (pollCount_reg <= 16'h0001)
                        state_reg <= ST_IDLE;
                    else
                        pollCount_reg <= pollCount_reg - 16'h0001;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Overrun while chaining, before the next entry is polled
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            overrunSeen_reg <= 1'b0;
        else if (state_reg == ST_DECIDE)
            overrunSeen_reg <= 1'b0;
        else if (pending_reg && fifoOverrun)
            overrunSeen_reg <= 1'b1;
    end

    // Capture flags of the buffer whose status goes out next
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            flgWord_reg <= 16'h0000;
            flgFirst_reg <= 1'b0;
            flgLast_reg <= 1'b0;
            flgFcs_reg <= 1'b0;
            flgNonOctet_reg <= 1'b0;
            flgOverrun_reg <= 1'b0;
            flgChain_reg <= 1'b0;
            flgSimult_reg <= 1'b0;
        end
        else if (state_reg == ST_GRANT && (fillDone || fifoOverrun))
        begin
            flgWord_reg <= hiWord_reg;
            flgFirst_reg <= firstNext_reg;
            flgLast_reg <= fillLast & ~fifoOverrun;
            flgFcs_reg <= fillFcsError;
            flgNonOctet_reg <= fillNonOctet;
            flgOverrun_reg <= fifoOverrun;
            flgChain_reg <= 1'b0;
            flgSimult_reg <= 1'b0;
        end
        else if (state_reg == ST_DECIDE && pending_reg)
        begin
            // Host-owned next entry or early overrun both fault the chain
            flgChain_reg <= ~ownedByController | overrunNow;
            flgOverrun_reg <= overrunNow;
            flgSimult_reg <= overrunNow & ~ownedByController;
        end
    end

    // Bookkeeping visible to software
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            lastStatus_reg <= 16'h0000;
            frameCount_reg <= 32'h0000_0000;
        end
        else if (state_reg == ST_WRITE && memAck)
        begin
            lastStatus_reg <= statusWord;
            if (statusWord[DESC_LAST_BIT] || statusWord[DESC_ERR_BIT])
                frameCount_reg <= frameCount_reg + 32'h0000_0001;
        end
    end

    rxwb_status_pack u_pack
    (
        .fetchedWord(flgWord_reg),
        .splitRxIrqMode(splitRxIrqMode),
        .loopback(loopback),
        .firstBuf(flgFirst_reg),
        .lastBuf(flgLast_reg),
        .fcsError(flgFcs_reg),
        .nonOctet(flgNonOctet_reg),
        .overrun(flgOverrun_reg),
        .chainFault(flgChain_reg),
        .simultaneous(flgSimult_reg),
        .statusWord(statusWord)
    );

    // Only the status word is ever written; other words stay host property
    assign memReq = (state_reg == ST_RD_LO) || (state_reg == ST_RD_HI) || (state_reg == ST_WRITE);
    assign memWe = (state_reg == ST_WRITE);
    assign memWdata = statusWord;
    assign bufGrant = (state_reg == ST_GRANT);
    assign bufAddr = {hiWord_reg[DESC_UPPER_MSB:0], lowWord_reg};
    assign chainAbort = chainAbort_reg;

endmodule

`default_nettype wire

// file: verilog/rxwb_pkg.sv
/*
  Shared constants for the receive descriptor status write-back engine:
  APB register offsets and fields, descriptor word layout, reset values
  and timing counts. Assumes a 20 MHz system clock.
*/
`default_nettype none

package rxwb_pkg;

    // APB register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RING_BASE = 8'h04;
    localparam logic [7:0] REG_RING_LEN = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_FRAME_COUNT = 8'h10;

    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_LOOPBACK_BIT = 1;
    localparam int CTRL_SPLIT_BIT = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [23:0] RING_BASE_RESET = 24'h00_0000;
    localparam logic [7:0] RING_LEN_RESET = 8'h01;

    // Descriptor second word layout
    localparam int DESC_OWN_BIT = 15;
    localparam int DESC_ERR_BIT = 14;
    localparam int DESC_FRAMING_BIT = 13;
    localparam int DESC_OVERRUN_BIT = 12;
    localparam int DESC_FCS_BIT = 11;
    localparam int DESC_CHAIN_BIT = 10;
    localparam int DESC_FIRST_BIT = 9;
    localparam int DESC_LAST_BIT = 8;
    localparam int DESC_UPPER_MSB = 7;

    // Descriptor geometry in bytes
    localparam logic [23:0] DESC_STRIDE = 24'h00_0008;
    localparam logic [23:0] WORD1_OFFSET = 24'h00_0002;

    // Delay between ownership polls of a host-owned entry
    localparam int CLOCK_MHZ = 20;
    localparam int POLL_TIME_NS = 1600;
    localparam int POLL_CYCLES = (POLL_TIME_NS * CLOCK_MHZ) / 1000;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_RD_LO = 3'b001,
        ST_RD_HI = 3'b010,
        ST_DECIDE = 3'b011,
        ST_GRANT = 3'b100,
        ST_WRITE = 3'b101,
        ST_POLL = 3'b110
    } rxwb_state_t;

    typedef enum logic [1:0]
    {
        AFTER_ADVANCE = 2'b00,
        AFTER_GRANT = 2'b01,
        AFTER_POLL = 2'b10
    } rxwb_after_t;

endpackage

`default_nettype wire

// file: verilog/rxwb_status_pack.sv
/*
  Builds the status word written back into a receive descriptor.
  Assumes its inputs are the flags captured for one buffer, held steady
  while the write is outstanding.
*/
`timescale 1ns/10ps
`default_nettype none

module rxwb_status_pack
    import rxwb_pkg::*;
(
    input wire logic [15:0] fetchedWord,
    input wire logic splitRxIrqMode,
    input wire logic loopback,
    input wire logic firstBuf,
    input wire logic lastBuf,
    input wire logic fcsError,
    input wire logic nonOctet,
    input wire logic overrun,
    input wire logic chainFault,
    input wire logic simultaneous,
    output logic [15:0] statusWord
);

    logic reportOverrun;
    logic lastBufferFlag;
    logic resultValid;
    logic fcsFlag;
    logic framingFaultFlag;
    logic errFlag;
    logic firstBufferFlag;

    // Overrun hidden behind a chain fault unless both struck together
    assign reportOverrun = overrun & (~chainFault | simultaneous);
    assign lastBufferFlag = lastBuf & ~overrun & ~chainFault;
    // Overrun flag only stands on a buffer without the last flag
    assign resultValid = lastBufferFlag & ~reportOverrun;
    assign fcsFlag = fcsError & resultValid;
    // Odd bit count alone never sets it; meaningless in loopback
    assign framingFaultFlag = fcsError & nonOctet & resultValid & ~loopback;
    assign errFlag = framingFaultFlag | reportOverrun | fcsFlag | chainFault;
    // In split mode the host owns the first flag, so keep its value
    assign firstBufferFlag = splitRxIrqMode ? fetchedWord[DESC_FIRST_BIT] : firstBuf;

    // Ownership returned in the same word as the status
    always_comb
    begin
        statusWord = 16'h0000;
        statusWord[DESC_OWN_BIT] = 1'b0;
        statusWord[DESC_ERR_BIT] = errFlag;
        statusWord[DESC_FRAMING_BIT] = framingFaultFlag;
        statusWord[DESC_OVERRUN_BIT] = reportOverrun;
        statusWord[DESC_FCS_BIT] = fcsFlag;
        statusWord[DESC_CHAIN_BIT] = chainFault;
        statusWord[DESC_FIRST_BIT] = firstBufferFlag;
        statusWord[DESC_LAST_BIT] = lastBufferFlag;
        statusWord[DESC_UPPER_MSB:0] = fetchedWord[DESC_UPPER_MSB:0];
    end

endmodule

`default_nettype wire

// file: test/rxwb_mem_model.sv
/*
  Descriptor memory seen by the engine: sixteen 16-bit words, four ring
  entries of four words each. Assumes a ring base whose low five bits are zero.
*/
`timescale 1ns/10ps
`default_nettype none

module rxwb_mem_model
    import rxwb_pkg::*;
(
    input wire logic clock,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [23:0] memAddr,
    input wire logic [15:0] memWdata,
    output logic memAck,
    output logic [15:0] memRdata
);
    logic [15:0] mem [16];
    logic [1:0] lat = 2'h0;
    logic [1:0] cnt = 2'h0;

    initial memAck = 1'b0;
    initial memRdata = 16'h0000;

    // Latency cycles 0..3 so both prompt and slow answers occur
    always @(posedge clock)
    begin
        memAck <= 1'b0;
        memRdata <= ~memRdata; // No stale data outside an answer
        if (memReq && !memAck)
        begin
            if (cnt == 2'h0)
            begin
                memAck <= 1'b1;
                memRdata <= mem[memAddr[4:1]];
                if (memWe)
                    mem[memAddr[4:1]] <= memWdata;
                lat <= lat + 2'h1;
                cnt <= lat + 2'h1;
            end
            else
                cnt <= cnt - 2'h1;
        end
    end
endmodule

`default_nettype wire

// file: test/rxwb_engine_assertions.sv
/*
  Checker for the descriptor engine ports. Assumes one clock domain and
  a design that writes only the status word of an entry.
*/
`timescale 1ns/10ps
`default_nettype none

module rxwb_engine_checker
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [23:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic memAck,
    input wire logic [15:0] memRdata,
    input wire logic bufGrant,
    input wire logic [23:0] bufAddr,
    input wire logic chainAbort
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic [15:0] rdLo;
    logic [15:0] rdHi;
    logic [7:0] upperSeen [256];

    // Last fetched words, and upper byte per status address
    always_ff @(posedge clock)
    begin
        if (memReq && memAck && !memWe && memAddr[1])
        begin
            rdHi <= memRdata;
            upperSeen[memAddr[7:0]] <= memRdata[7:0];
        end
        if (memReq && memAck && !memWe && !memAddr[1])
            rdLo <= memRdata;
    end

    sequence wbWrite;
        memReq && memWe && memAck;
    endsequence

    sequence grantStart;
        $rose(bufGrant);
    endsequence

    own_clear_a: assert property (wbWrite |-> !memWdata[15]) else $error("ownership kept");
    err_summary_a: assert property (wbWrite |-> memWdata[14] == (|memWdata[13:10])) else $error("bad summary");
    framing_cause_a: assert property ((wbWrite and memWdata[13]) |-> memWdata[11]) else $error("framing alone");
    framing_valid_a: assert property ((wbWrite and memWdata[13]) |-> memWdata[8] && !memWdata[12])
        else $error("framing misplaced");
    overrun_nolast_a: assert property ((wbWrite and memWdata[12]) |-> !memWdata[8]) else $error("overrun on last");
    upper_keep_a: assert property (wbWrite |-> memWdata[7:0] == upperSeen[memAddr[7:0]])
        else $error("upper byte altered");
    buf_addr_a: assert property (grantStart |-> bufAddr == {rdHi[7:0], rdLo}) else $error("bad buffer address");
    grant_own_a: assert property (grantStart |-> rdHi[15]) else $error("grant without ownership");
    req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
        else $error("request dropped");
    word1_only_a: assert property (memReq && memWe |-> memAddr[1]) else $error("wrote other word");
    abort_pulse_a: assert property (chainAbort |=> !chainAbort) else $error("abort too long");
    unmapped_err_a: assert property (psel && penable && paddr > 8'h10 |-> pslverr) else $error("no slave error");
endmodule

bind rxwb_engine rxwb_engine_checker CHK
(
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .bufGrant(bufGrant), .bufAddr(bufAddr), .chainAbort(chainAbort)
);

`default_nettype wire

// file: test/test_rx_descriptor_status_writeback.sv
/*
  Bench for the descriptor engine: APB set-up, a four-entry ring in the
  memory model, and datapath fill events. Assumes zero or more APB waits.
*/
`timescale 1ns/10ps
`default_nettype none

module test_rx_descriptor_status_writeback;
    import rxwb_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic memReq, memWe, memAck;
    logic [23:0] memAddr, bufAddr;
    logic [15:0] memWdata, memRdata;
    logic bufGrant, chainAbort;
    logic fillDone = 1'b0, fillLast = 1'b0, fillFcsError = 1'b0, fillNonOctet = 1'b0, fifoOverrun = 1'b0;
    int mismatches = 0;
    int n_checks = 0;
    int k;

    always #25 clock = ~clock;

    rxwb_engine DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
        .memRdata(memRdata), .bufGrant(bufGrant), .bufAddr(bufAddr), .fillDone(fillDone),
        .fillLast(fillLast), .fillFcsError(fillFcsError), .fillNonOctet(fillNonOctet),
        .fifoOverrun(fifoOverrun), .chainAbort(chainAbort));

    rxwb_mem_model mem0 (.clock(clock), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
        .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded waits end the run instead of hanging
    task automatic giveUp(input string what);
        check(what, 32'h0000_0000, 32'h0000_0001);
        summarize();
    endtask

    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
        end
        if (i == 50)
            giveUp("apb wait");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits for a grant, then one event pulse with its qualifiers
    task automatic fill(input logic d, input logic l, input logic f, input logic n, input logic o);
        int i;
        for (i = 0; i < 400; i++)
        begin
            @(posedge clock);
            if (bufGrant === 1'b1)
                break;
        end
        if (i == 400)
            giveUp("grant wait");
        fillDone <= d;
        fillLast <= l;
        fillFcsError <= f;
        fillNonOctet <= n;
        fifoOverrun <= o;
        @(posedge clock);
        fillDone <= 1'b0;
        fifoOverrun <= 1'b0;
    endtask

    // Status is judged once ownership returns, so it must be whole then
    task automatic waitStatus(input int e, input logic [15:0] exp);
        int i;
        for (i = 0; i < 400 && mem0.mem[4*e+1][15] !== 1'b0; i++)
            @(posedge clock);
        if (i == 400)
            giveUp("status wait");
        check("status", {16'h0000, mem0.mem[4*e+1]}, {16'h0000, exp});
    endtask

    initial
    begin
        // Host fills the ring before handing it over
        for (k = 0; k < 4; k++)
        begin
            mem0.mem[4*k] = 16'h1111 * k[15:0];
            mem0.mem[4*k+1] = 16'h8000 | k[15:0];
            mem0.mem[4*k+2] = 16'hF000;
        end
        mem0.mem[0] = 16'h1234;
        mem0.mem[1] = 16'h80AB;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl reset", rd, CTRL_RESET);
        apb(1'b0, REG_RING_LEN, 32'h0);
        check("ring length reset", rd, {24'h0, RING_LEN_RESET});
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b1, REG_RING_BASE, 32'h0000_0100);
        apb(1'b1, REG_RING_LEN, 32'h0000_0004);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        fill(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        check("buffer address", {8'h0, bufAddr}, 32'h00AB_1234);
        waitStatus(0, 16'h6BAB);
        fill(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        fill(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        waitStatus(1, 16'h0201);
        waitStatus(2, 16'h5002);
        // Next entry is host owned while chaining
        fill(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        for (k = 0; k < 400 && chainAbort !== 1'b1; k++)
            @(posedge clock);
        check("chain abort", {31'h0, chainAbort}, 32'h1);
        waitStatus(3, 16'h4603);
        apb(1'b0, REG_FRAME_COUNT, 32'h0);
        check("frame count", rd, 32'h0000_0003);
        // Loopback and split mode: host owns the first flag
        apb(1'b1, REG_CTRL, 32'h0000_0023);
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl", rd, 32'h0000_0023);
        mem0.mem[1] <= 16'h80AB;
        fill(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        waitStatus(0, 16'h49AB);
        // Overrun while chaining into a host-owned entry: both faults together
        mem0.mem[5] <= 16'h8001;
        fill(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge clock);
        fifoOverrun <= 1'b1;
        @(posedge clock);
        fifoOverrun <= 1'b0;
        waitStatus(1, 16'h5401);
        apb(1'b0, REG_STATUS, 32'h0);
        check("last status", {16'h0000, rd[15:0]}, 32'h0000_5401);
        check("third word", {16'h0000, mem0.mem[2]}, 32'h0000_F000);
        summarize();
    end
endmodule

`default_nettype wire
